//--- rtl/rotate_right_and_set_file_exec.sv
// Operation
// [RULE1] rotate right, bit 0 wraps to bit 7
// [RULE2] d=0 writes W, d=1 writes file
// [RULE3] a=0 selects access bank, ignores bank register
// [RULE4] a=1 addresses bank register plus operand
// [RULE5] extended set, a=0, f<=95: indexed offset
// [RULE6] set operation writes all ones
// [RULE7] opcode decode, one cycle, rotate sets N,Z
module rotate_right_and_set_file_exec #(
  parameter int FAW = rrset_pkg::EAW
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rrset_pkg::PAW-1:0] paddr,
  input wire logic [rrset_pkg::DW-1:0] pwdata,
  output logic [rrset_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr
);
  import rrset_pkg::*;

  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [DW-1:0] prdata_q, prdata_d;
  logic [DW-1:0] rd_data;
  logic rd_ok;
  logic ext_en_q, ext_en_d;
  logic [BANK_SEL_W-1:0] bank_select_reg_q, bank_select_reg_d;
  logic [EAW-1:0] ibase_q, ibase_d;
  logic [EAW-1:0] faddr_q, faddr_d;
  logic [EAW-1:0] ea_q, ea_d;
  logic [EAW-1:0] ea_gen;
  logic [IW-1:0] instr_q, instr_d;
  logic [BYTE_W-1:0] w_q, w_d;
  logic [BYTE_W-1:0] opnd_q, opnd_d;
  logic [BYTE_W-1:0] res_q, res_d;
  logic n_q, n_d;
  logic z_q, z_d;
  logic ill_q, ill_d;
  logic idx_q, idx_d;
  logic idx_gen;
  logic [BYTE_W-1:0] mem_q [1<<FAW];
  logic mem_we;
  logic [FAW-1:0] mem_wa;
  logic [BYTE_W-1:0] mem_wd;
  logic [FAW-1:0] ea_idx;
  phase_t phase;
  logic access, take, wr, start, busy;
  logic is_r, is_s;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // a transfer completes at the edge where pready_q is seen high
  assign access = psel && penable;
  assign take = access && pready_q;
  assign wr = take && pwrite;
  assign start = wr && (paddr == OFF_INSTR);
  assign busy = (phase != PH_IDLE);
  assign is_r = is_rot(instr_q);
  assign is_s = is_set(instr_q);
  assign ea_idx = ea_q[FAW-1:0];

  q_phase_seq u_seq (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .start(start),
    .phase(phase)
  );

  file_addr_gen u_addr (
    .f(instr_q[BYTE_W-1:0]),
    .abit(instr_q[A_BIT]),
    .ext_en(ext_en_q),
    .bank_select_reg(bank_select_reg_q),
    .ibase(ibase_q),
    .ea(ea_gen),
    .indexed(idx_gen)
  );

  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    case (paddr)
      OFF_CTRL: rd_data[CTRL_EXT_BIT] = ext_en_q;
      OFF_INSTR: rd_data[IW-1:0] = instr_q;
      OFF_BANK: rd_data[BANK_SEL_W-1:0] = bank_select_reg_q;
      OFF_WREG: rd_data[BYTE_W-1:0] = w_q;
      OFF_STATUS: begin
        rd_data[ST_BUSY] = busy;
        rd_data[ST_Z] = z_q;
        rd_data[ST_N] = n_q;
        rd_data[ST_ILL] = ill_q;
        rd_data[ST_IDX] = idx_q;
      end
      OFF_IBASE: rd_data[EAW-1:0] = ibase_q;
      OFF_FADDR: rd_data[EAW-1:0] = faddr_q;
      OFF_FDATA: rd_data[BYTE_W-1:0] = mem_q[faddr_q[FAW-1:0]];
      OFF_LASTEA: rd_data[EAW-1:0] = ea_q;
      default: rd_ok = 1'b0;
    endcase
  end

  // one wait state; the bus stalls while an instruction is in flight,
  // so software never sees half-written state
  always_comb begin
    pready_d = access && !pready_q && !busy;
    prdata_d = pready_d ? rd_data : '0;
    pslverr_d = pready_d && !rd_ok;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  always_comb begin
    ext_en_d = ext_en_q;
    bank_select_reg_d = bank_select_reg_q;
    ibase_d = ibase_q;
    faddr_d = faddr_q;
    instr_d = instr_q;
    w_d = w_q;
    ea_d = ea_q;
    opnd_d = opnd_q;
    res_d = res_q;
    n_d = n_q;
    z_d = z_q;
    ill_d = ill_q;
    idx_d = idx_q;
    mem_we = 1'b0;
    mem_wa = faddr_q[FAW-1:0];
    mem_wd = pwdata[BYTE_W-1:0];
    if (wr) begin
      case (paddr)
        OFF_CTRL: ext_en_d = pwdata[CTRL_EXT_BIT];
        OFF_INSTR: instr_d = pwdata[IW-1:0];
        OFF_BANK: bank_select_reg_d = pwdata[BANK_SEL_W-1:0];
        OFF_WREG: w_d = pwdata[BYTE_W-1:0];
        OFF_IBASE: ibase_d = pwdata[EAW-1:0];
        OFF_FADDR: faddr_d = pwdata[EAW-1:0];
        OFF_FDATA: mem_we = 1'b1;
        default: ;
      endcase
    end
    unique case (phase)
      PH_IDLE: ;
      PH_DECODE: begin
        // [RULE7] opcode decode step
        ill_d = !(is_r || is_s);
        ea_d = ea_gen;
        idx_d = idx_gen;
      end
      PH_READ: opnd_d = mem_q[ea_idx];
      PH_PROCESS: begin
        // [RULE1] rotate without carry
        if (is_r) begin
          res_d = {opnd_q[0], opnd_q[BYTE_W-1:1]};
        end else begin
          // [RULE6] force all ones
          res_d = ONES;
        end
      end
      PH_WRITE: begin
        if (!ill_q) begin
          // [RULE2] destination select
          if (is_r && !instr_q[D_BIT]) begin
            w_d = res_q;
          end else begin
            mem_we = 1'b1;
            mem_wa = ea_idx;
            mem_wd = res_q;
          end
          // [RULE7] rotate flags only
          if (is_r) begin
            n_d = res_q[BYTE_W-1];
            z_d = (res_q == ZERO8);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_en_q <= 1'b0;
      bank_select_reg_q <= LOW_BANK;
      ibase_q <= '0;
      faddr_q <= '0;
      instr_q <= INSTR_RST;
      w_q <= ZERO8;
      ea_q <= '0;
      opnd_q <= ZERO8;
      res_q <= ZERO8;
      n_q <= 1'b0;
      z_q <= 1'b0;
      ill_q <= 1'b0;
      idx_q <= 1'b0;
    end else if (ce) begin
      ext_en_q <= ext_en_d;
      bank_select_reg_q <= bank_select_reg_d;
      ibase_q <= ibase_d;
      faddr_q <= faddr_d;
      instr_q <= instr_d;
      w_q <= w_d;
      ea_q <= ea_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      n_q <= n_d;
      z_q <= z_d;
      ill_q <= ill_d;
      idx_q <= idx_d;
    end
  end

  // file storage; only FAW low address bits are kept, higher bits alias
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < (1 << FAW); i++) begin
        mem_q[i] <= ZERO8;
      end
    end else if (ce && mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // [RULE1] value lands in W
  a_rot_to_w: assert property ( // [RULE2]
    (phase == PH_WRITE && ce && is_r && !ill_q && !instr_q[D_BIT])
    |=> w_q == {opnd_q[0], opnd_q[BYTE_W-1:1]})
    else $error("rotate to W gave wrong value");

  // [RULE2] file write keeps W
  a_rot_to_file: assert property ( // [RULE2]
    (phase == PH_WRITE && ce && is_r && !ill_q && instr_q[D_BIT])
    |=> mem_q[$past(ea_idx)] == {opnd_q[0], opnd_q[BYTE_W-1:1]} && w_q == $past(w_q))
    else $error("rotate to file wrong or W disturbed");

  // [RULE3] access bank map
  a_access_bank: assert property ( // [RULE3]
    (phase == PH_DECODE && ce && !instr_q[A_BIT] && !(ext_en_q && instr_q[BYTE_W-1:0] <= IDX_LIMIT))
    |=> ea_q == {(instr_q[BYTE_W-1:0] >= ACC_SPLIT) ? SFR_BANK : LOW_BANK, instr_q[BYTE_W-1:0]} && !idx_q)
    else $error("access bank address wrong");

  // [RULE4] banked address
  a_bank_addr: assert property ( // [RULE4]
    (phase == PH_DECODE && ce && instr_q[A_BIT])
    |=> ea_q == {bank_select_reg_q, instr_q[BYTE_W-1:0]})
    else $error("banked address wrong");

  // [RULE5] indexed offset address
  a_indexed_addr: assert property ( // [RULE5]
    (phase == PH_DECODE && ce && !instr_q[A_BIT] && ext_en_q && instr_q[BYTE_W-1:0] <= IDX_LIMIT)
    |=> idx_q && ea_q == ibase_q + EAW'(instr_q[BYTE_W-1:0]))
    else $error("indexed address wrong");

  // [RULE6] set writes ones
  a_set_ones: assert property ( // [RULE6]
    (phase == PH_WRITE && ce && is_s && !ill_q)
    |=> mem_q[$past(ea_idx)] == ONES && w_q == $past(w_q))
    else $error("set did not write all ones");

  // [RULE7] one instruction cycle
  a_one_cycle: assert property ( // [RULE7]
    (phase == PH_DECODE && ce) ##1 ce [*3] |=> phase == PH_IDLE)
    else $error("instruction did not finish in four steps");

  // [RULE7] rotate flag update
  a_rot_flags: assert property ( // [RULE7]
    (phase == PH_WRITE && ce && is_r && !ill_q)
    |=> n_q == opnd_q[0] && z_q == (opnd_q == ZERO8))
    else $error("rotate flags wrong");

  // [RULE7] set leaves flags
  a_set_flags: assert property ( // [RULE7]
    (phase == PH_WRITE && ce && is_s)
    |=> n_q == $past(n_q) && z_q == $past(z_q))
    else $error("set changed flags");

  // [RULE7] unknown opcode flagged
  a_decode_ill: assert property ( // [RULE7]
    (phase == PH_DECODE && ce && !is_r && !is_s) |=> ill_q)
    else $error("illegal opcode not flagged");

  c_rot_w: cover property (phase == PH_WRITE && ce && is_r && !instr_q[D_BIT]);
  c_rot_f: cover property (phase == PH_WRITE && ce && is_r && instr_q[D_BIT]);
  c_set: cover property (phase == PH_WRITE && ce && is_s);
  c_indexed: cover property (phase == PH_WRITE && ce && idx_q && !ill_q);
endmodule : rotate_right_and_set_file_exec

//--- pkg/rrset_pkg.sv
package rrset_pkg;
  // bus and datapath widths
  localparam int DW = 32;
  localparam int PAW = 8;
  localparam int BYTE_W = 8;
  localparam int EAW = 12;
  localparam int BANK_SEL_W = 4;
  localparam int IW = 16;

  // register offsets (byte addresses)
  localparam logic [PAW-1:0] OFF_CTRL = 8'h00;
  localparam logic [PAW-1:0] OFF_INSTR = 8'h04;
  localparam logic [PAW-1:0] OFF_BANK = 8'h08;
  localparam logic [PAW-1:0] OFF_WREG = 8'h0C;
  localparam logic [PAW-1:0] OFF_STATUS = 8'h10;
  localparam logic [PAW-1:0] OFF_IBASE = 8'h14;
  localparam logic [PAW-1:0] OFF_FADDR = 8'h18;
  localparam logic [PAW-1:0] OFF_FDATA = 8'h1C;
  localparam logic [PAW-1:0] OFF_LASTEA = 8'h20;

  // field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_Z = 1;
  localparam int ST_N = 2;
  localparam int ST_ILL = 3;
  localparam int ST_IDX = 4;
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;
  localparam int ROT_LSB = 10;
  localparam int SET_LSB = 9;

  // opcodes and constants
  localparam logic [IW-1:ROT_LSB] OPC_ROT = 6'h10;
  localparam logic [IW-1:SET_LSB] OPC_SET = 7'h34;
  localparam logic [BYTE_W-1:0] ACC_SPLIT = 8'h80;
  localparam logic [BYTE_W-1:0] IDX_LIMIT = 8'h5F;
  localparam logic [BYTE_W-1:0] ONES = 8'hFF;
  localparam logic [BYTE_W-1:0] ZERO8 = 8'h00;
  localparam logic [BANK_SEL_W-1:0] SFR_BANK = 4'hF;
  localparam logic [BANK_SEL_W-1:0] LOW_BANK = 4'h0;
  localparam logic [IW-1:0] INSTR_RST = 16'h0000;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_DECODE = 3'b001,
    PH_READ = 3'b010,
    PH_PROCESS = 3'b011,
    PH_WRITE = 3'b100
  } phase_t;

  function automatic logic is_rot(input logic [IW-1:0] iw);
    return iw[IW-1:ROT_LSB] == OPC_ROT;
  endfunction : is_rot

  function automatic logic is_set(input logic [IW-1:0] iw);
    return iw[IW-1:SET_LSB] == OPC_SET;
  endfunction : is_set
endpackage : rrset_pkg

//--- rtl/q_phase_seq.sv
module q_phase_seq (
  // clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // control
  input wire logic start,
  output rrset_pkg::phase_t phase
);
  import rrset_pkg::*;

  phase_t phase_q;
  phase_t phase_d;

  assign phase = phase_q;

  // [RULE7] four quarter steps
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      PH_IDLE: begin
        if (start) begin
          phase_d = PH_DECODE;
        end
      end
      PH_DECODE: phase_d = PH_READ;
      PH_READ: phase_d = PH_PROCESS;
      PH_PROCESS: phase_d = PH_WRITE;
      PH_WRITE: phase_d = PH_IDLE;
      default: phase_d = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= PH_IDLE;
    end else if (ce) begin
      phase_q <= phase_d;
    end
  end
endmodule : q_phase_seq

//--- rtl/file_addr_gen.sv
module file_addr_gen (
  // operand fields
  input wire logic [rrset_pkg::BYTE_W-1:0] f,
  input wire logic abit,
  // addressing state
  input wire logic ext_en,
  input wire logic [rrset_pkg::BANK_SEL_W-1:0] bank_select_reg,
  input wire logic [rrset_pkg::EAW-1:0] ibase,
  // effective address
  output logic [rrset_pkg::EAW-1:0] ea,
  output logic indexed
);
  import rrset_pkg::*;

  always_comb begin
    indexed = 1'b0;
    if (abit) begin
      // [RULE4] bank select address
      ea = {bank_select_reg, f};
    end else if (ext_en && f <= IDX_LIMIT) begin
      // [RULE5] indexed literal offset
      indexed = 1'b1;
      ea = ibase + EAW'(f);
    end else begin
      // [RULE3] access bank map
      ea = {(f >= ACC_SPLIT) ? SFR_BANK : LOW_BANK, f};
    end
  end
endmodule : file_addr_gen

//--- test/rotate_right_and_set_file_exec_bench.sv
module rotate_right_and_set_file_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rrset_pkg::*;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PAW-1:0] paddr = 8'h00;
  logic [DW-1:0] pwdata = 32'h0000_0000;
  logic [DW-1:0] prdata;
  logic pready;
  logic pslverr;
  int bad_count = 0;
  int compares = 0;
  logic [DW-1:0] rd_v;
  logic err_v;

  rotate_right_and_set_file_exec u_rotate_right_and_set_file_exec (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  always #20 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // request held up to the rising edge that samples pready high; only the watchdog ends a wait
  task automatic apb(input logic w, input logic [PAW-1:0] a, input logic [DW-1:0] wd,
                     output logic [DW-1:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [PAW-1:0] a, input logic [DW-1:0] d);
    apb(1'b1, a, d, rd_v, err_v);
  endtask : wr

  task automatic rc(input logic [PAW-1:0] a, input logic [DW-1:0] exp, input string name);
    apb(1'b0, a, 32'h0000_0000, rd_v, err_v);
    chk(name, rd_v, exp);
  endtask : rc

  // seed the target byte and W, run one instruction, then read back every visible effect
  task automatic op(input logic [IW-1:0] ins, input logic [EAW-1:0] ea, input logic [7:0] init,
                    input logic [7:0] fexp, input logic [7:0] wexp, input logic [7:0] stexp);
    wr(OFF_WREG, 32'h0000_0033);
    wr(OFF_FADDR, {20'h0_0000, ea});
    wr(OFF_FDATA, {24'h00_0000, init});
    wr(OFF_INSTR, {16'h0000, ins});
    rc(OFF_FDATA, {24'h00_0000, fexp}, "fdata");
    rc(OFF_WREG, {24'h00_0000, wexp}, "wreg");
    rc(OFF_STATUS, {24'h00_0000, stexp}, "status");
    rc(OFF_LASTEA, {20'h0_0000, ea}, "lastea");
  endtask : op

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("Error watchdog expected done seen hang");
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rc(OFF_STATUS, 32'h0000_0000, "status_rst");
    rc(OFF_CTRL, 32'h0000_0000, "ctrl_rst");
    apb(1'b0, 8'h40, 32'h0000_0000, rd_v, err_v);
    chk("unmapped_err", {31'h0000_0000, err_v}, 32'h0000_0001);
    chk("unmapped_data", rd_v, 32'h0000_0000);
    wr(OFF_BANK, 32'h0000_0002);
    // bank register used, result back to file, negative flag
    op({OPC_ROT, 1'b1, 1'b1, 8'h34}, 12'h234, 8'hD7, 8'hEB, 8'h33, 8'h04);
    // access bank high half, bank register ignored, result to W
    op({OPC_ROT, 1'b0, 1'b0, 8'h90}, 12'hF90, 8'hD7, 8'hD7, 8'hEB, 8'h04);
    op({OPC_ROT, 1'b1, 1'b0, 8'h12}, 12'h012, 8'h00, 8'h00, 8'h33, 8'h02);
    op({OPC_ROT, 1'b1, 1'b1, 8'h01}, 12'h201, 8'h01, 8'h80, 8'h33, 8'h04);
    // set leaves the flags of the previous rotate alone
    op({OPC_SET, 1'b1, 8'h55}, 12'h255, 8'h5A, 8'hFF, 8'h33, 8'h04);
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_IBASE, 32'h0000_0100);
    op({OPC_SET, 1'b0, 8'h5F}, 12'h15F, 8'h00, 8'hFF, 8'h33, 8'h14);
    op({OPC_ROT, 1'b1, 1'b0, 8'h60}, 12'h060, 8'h02, 8'h01, 8'h33, 8'h00);
    op({OPC_ROT, 1'b0, 1'b0, 8'h00}, 12'h100, 8'hFF, 8'hFF, 8'hFF, 8'h14);
    op({OPC_SET, 1'b1, 8'h00}, 12'h200, 8'h00, 8'hFF, 8'h33, 8'h04);
    // unknown opcode raises the illegal flag and writes nothing
    op(16'h0000, 12'h100, 8'h5A, 8'h5A, 8'h33, 8'h1C);
    print_verdict();
  end
endmodule : rotate_right_and_set_file_exec_bench
